// >>> hdl/pmc_defs.svh
// Offsets, field positions, reset values and timing counts of the power mode clock switch.
// Assumes a 50 MHz system clock and 32-bit APB data.
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_ADDR_CTRL 12'h000
`define PMC_ADDR_STAT 12'h004
`define PMC_CTRL_RST 7'h00
`define PMC_CTRL_W 7
`define PMC_F_SCS_LO 0
`define PMC_F_SCS_HI 1
`define PMC_F_SECFORCE 2
`define PMC_F_IDLESEL 3
`define PMC_F_TWOSPEED 4
`define PMC_F_FSCM 5
`define PMC_F_WDTSEL 6
`define PMC_F_PRIACT 0
`define PMC_F_INTSTB 1
`define PMC_F_SECRUN 2
`define PMC_F_CPURUN 3
`define PMC_F_SWITCH 4
`define PMC_F_ASLEEP 5
`define PMC_CLK_NS 20
`define PMC_CPU_START_NS 1000
`define PMC_CPU_START_CYC ((`PMC_CPU_START_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_OLD_TICKS 2
`define PMC_NEW_TICKS 3
`endif

// >>> hdl/pmc_pkg.sv
// Types shared by the power mode clock switch.
// Assumes nothing beyond the defs header.
package pmc_pkg;
  typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} pmc_src_t;
  typedef enum logic [2:0] {ST_RUN, ST_SW_OLD, ST_SW_NEW, ST_SLEEP, ST_WAKE, ST_IDLE, ST_IDLE_DLY} pmc_state_t;
endpackage : pmc_pkg

// >>> hdl/pmc_clock_switch.sv
// Power mode controller and glitch-free device clock switch, with an APB register port.
// Assumes oscillator ready levels arrive asynchronously; ticks, sleep and wake come from logic on clk.
`include "pmc_defs.svh"
module pmc_clock_switch #(
  parameter int CPU_START_CYC = `PMC_CPU_START_CYC
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic priReady, // Primary oscillator ready, async
  input wire logic secReady, // Secondary oscillator ready, async
  input wire logic intReady, // Internal block ready, async
  input wire logic priTick, // One pulse per primary clock cycle
  input wire logic secTick, // One pulse per secondary clock cycle
  input wire logic intTick, // One pulse per internal clock cycle
  input wire logic sleepExec, // Sleep instruction executed, pulse
  input wire logic wakeIrq, // Interrupt wake, pulse or level
  input wire logic wdtTimeout, // Watchdog timeout, pulse
  output pmc_pkg::pmc_src_t srcSel, // Device clock mux select
  output logic srcGate, // Device clock gate enable
  output logic cpuClkEn, // CPU clock enable
  output logic periphClkEn, // Peripheral clock enable
  output logic priOscEn, // Primary oscillator enable
  output logic secOscEn, // Secondary oscillator enable
  output logic intOscEn, // Internal block enable
  output logic lfOscEn, // Low-frequency internal oscillator enable
  output logic primaryActive, // Primary is driving the clocks
  output logic intStable, // Internal block is driving the clocks
  output logic secRunning // Secondary is driving the clocks
);
  pmc_pkg::pmc_state_t state_q;
  pmc_pkg::pmc_src_t curSrc_q;
  pmc_pkg::pmc_src_t swTgt_q;
  pmc_pkg::pmc_src_t tgtSrc;
  logic [`PMC_CTRL_W-1:0] ctrl_q;
  logic [2:0] rdyMeta_q;
  logic [2:0] rdySync_q;
  logic [2:0] flags_q;
  logic [1:0] tickCnt_q;
  logic [15:0] dlyCnt_q;
  logic [2:0] priEn_q;
  logic secKeep_q;
  logic [1:0] clock_source_select;
  logic idleSel;
  logic secForce;
  logic fastWake;
  logic wake;
  logic tgtReady;
  logic oldTick;
  logic newTick;
  logic apbAcc;
  logic addrOk;

  function automatic pmc_pkg::pmc_src_t decodeSrc(input logic [1:0] sel);
    unique case (sel)
      2'h0: decodeSrc = pmc_pkg::SRC_PRI;
      2'h1: decodeSrc = pmc_pkg::SRC_SEC;
      default: decodeSrc = pmc_pkg::SRC_INT;
    endcase
  endfunction : decodeSrc

  function automatic logic pickBit(input pmc_pkg::pmc_src_t s, input logic [2:0] v);
    unique case (s)
      pmc_pkg::SRC_PRI: pickBit = v[0];
      pmc_pkg::SRC_SEC: pickBit = v[1];
      default: pickBit = v[2];
    endcase
  endfunction : pickBit

  function automatic logic [2:0] flagsOf(input pmc_pkg::pmc_src_t s);
    flagsOf = 3'h0;
    flagsOf[`PMC_F_PRIACT] = (s == pmc_pkg::SRC_PRI);
    flagsOf[`PMC_F_INTSTB] = (s == pmc_pkg::SRC_INT);
    flagsOf[`PMC_F_SECRUN] = (s == pmc_pkg::SRC_SEC);
  endfunction : flagsOf

  assign clock_source_select = ctrl_q[`PMC_F_SCS_HI:`PMC_F_SCS_LO];
  assign idleSel = ctrl_q[`PMC_F_IDLESEL];
  assign secForce = ctrl_q[`PMC_F_SECFORCE];
  assign fastWake = ctrl_q[`PMC_F_TWOSPEED] | ctrl_q[`PMC_F_FSCM];
  assign tgtSrc = decodeSrc(clock_source_select);
  assign wake = wakeIrq | wdtTimeout;
  assign tgtReady = pickBit(tgtSrc, rdySync_q);
  assign oldTick = pickBit(curSrc_q, {intTick, secTick, priTick});
  assign newTick = pickBit(swTgt_q, {intTick, secTick, priTick});
  assign apbAcc = psel & penable;
  assign addrOk = (paddr == `PMC_ADDR_CTRL) | (paddr == `PMC_ADDR_STAT);

  // Ready levels cross in from the oscillators
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdyMeta_q <= 3'h0;
      rdySync_q <= 3'h0;
    end else begin
      rdyMeta_q <= {intReady, secReady, priReady};
      rdySync_q <= rdyMeta_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `PMC_CTRL_RST;
    end else if (apbAcc && pwrite && paddr == `PMC_ADDR_CTRL) begin
      ctrl_q <= pwdata[`PMC_CTRL_W-1:0];
    end
  end

  assign pready = 1'b1;
  assign pslverr = apbAcc & ~addrOk;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (paddr == `PMC_ADDR_CTRL) begin
        prdata[`PMC_CTRL_W-1:0] <= ctrl_q;
      end else if (paddr == `PMC_ADDR_STAT) begin
        prdata[2:0] <= flags_q;
        prdata[`PMC_F_CPURUN] <= cpuClkEn;
        prdata[`PMC_F_SWITCH] <= (state_q == pmc_pkg::ST_SW_OLD) | (state_q == pmc_pkg::ST_SW_NEW);
        prdata[`PMC_F_ASLEEP] <= (state_q == pmc_pkg::ST_SLEEP) | (state_q == pmc_pkg::ST_WAKE);
      end
    end
  end

  // Mode sequencer; reset lands in the wake state with the primary selected, waiting for the primary to become ready
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= pmc_pkg::ST_WAKE;
      curSrc_q <= pmc_pkg::SRC_PRI;
      swTgt_q <= pmc_pkg::SRC_PRI;
      tickCnt_q <= 2'h0;
      dlyCnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        pmc_pkg::ST_RUN, pmc_pkg::ST_SW_OLD: begin
          if (sleepExec) begin
            state_q <= idleSel ? pmc_pkg::ST_IDLE : pmc_pkg::ST_SLEEP;
          end else if (state_q == pmc_pkg::ST_RUN) begin
            if (tgtSrc != curSrc_q && tgtReady) begin
              state_q <= pmc_pkg::ST_SW_OLD;
              swTgt_q <= tgtSrc;
              tickCnt_q <= 2'h0;
            end
          end else if (!pickBit(swTgt_q, rdySync_q)) begin
            state_q <= pmc_pkg::ST_RUN;
          end else if (oldTick) begin
            if (tickCnt_q == 2'(`PMC_OLD_TICKS - 1)) begin
              state_q <= pmc_pkg::ST_SW_NEW;
              tickCnt_q <= 2'h0;
            end else begin
              tickCnt_q <= tickCnt_q + 2'h1;
            end
          end
        end
        pmc_pkg::ST_SW_NEW: begin
          if (newTick) begin
            if (tickCnt_q == 2'(`PMC_NEW_TICKS - 1)) begin
              state_q <= pmc_pkg::ST_RUN;
              curSrc_q <= swTgt_q;
              tickCnt_q <= 2'h0;
            end else begin
              tickCnt_q <= tickCnt_q + 2'h1;
            end
          end
        end
        pmc_pkg::ST_SLEEP: begin
          if (wake) begin
            state_q <= pmc_pkg::ST_WAKE;
          end
        end
        pmc_pkg::ST_WAKE: begin
          if (tgtReady) begin
            state_q <= pmc_pkg::ST_RUN;
            curSrc_q <= tgtSrc;
          end else if (fastWake && rdySync_q[2]) begin
            state_q <= pmc_pkg::ST_RUN;
            curSrc_q <= pmc_pkg::SRC_INT;
          end
        end
        pmc_pkg::ST_IDLE: begin
          if (wake) begin
            state_q <= pmc_pkg::ST_IDLE_DLY;
            dlyCnt_q <= 16'(CPU_START_CYC);
          end
        end
        pmc_pkg::ST_IDLE_DLY: begin
          if (dlyCnt_q <= 16'h0001) begin
            state_q <= pmc_pkg::ST_RUN;
          end else begin
            dlyCnt_q <= dlyCnt_q - 16'h0001;
          end
        end
        default: begin
          state_q <= pmc_pkg::ST_WAKE;
        end
      endcase
    end
  end

  // Clock-source flags
  // idle leaves flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= 3'h0;
    end else if (state_q != pmc_pkg::ST_IDLE && (state_q == pmc_pkg::ST_RUN || state_q == pmc_pkg::ST_SW_OLD)
                 && sleepExec && !idleSel) begin
      flags_q <= 3'h0;
    end else if (state_q == pmc_pkg::ST_SW_NEW && newTick && tickCnt_q == 2'(`PMC_NEW_TICKS - 1)) begin
      flags_q <= flagsOf(swTgt_q);
    end else if (state_q == pmc_pkg::ST_WAKE) begin
      if (tgtReady) begin
        flags_q <= flagsOf(tgtSrc);
      end else if (fastWake && rdySync_q[2]) begin
        flags_q <= flagsOf(pmc_pkg::SRC_INT);
      end
    end
  end

  assign primaryActive = flags_q[`PMC_F_PRIACT];
  assign intStable = flags_q[`PMC_F_INTSTB];
  assign secRunning = flags_q[`PMC_F_SECRUN];

  assign srcSel = (state_q == pmc_pkg::ST_SW_NEW) ? swTgt_q : curSrc_q;
  assign srcGate = (state_q == pmc_pkg::ST_RUN) | (state_q == pmc_pkg::ST_SW_OLD)
                   | (state_q == pmc_pkg::ST_IDLE) | (state_q == pmc_pkg::ST_IDLE_DLY);
  assign cpuClkEn = (state_q == pmc_pkg::ST_RUN) | (state_q == pmc_pkg::ST_SW_OLD);
  assign periphClkEn = srcGate;

  // secondary stays on
  // Once it has clocked the device the secondary stays on after a switch back; only sleep may stop it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      secKeep_q <= 1'b0;
    end else if (state_q == pmc_pkg::ST_SLEEP) begin
      secKeep_q <= 1'b0;
    end else if (state_q == pmc_pkg::ST_RUN && curSrc_q == pmc_pkg::SRC_SEC) begin
      secKeep_q <= 1'b1;
    end
  end

  // Oscillator enables; a source is wanted while it drives or is the switch target
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      priEn_q <= 3'h1;
      lfOscEn <= 1'b0;
    end else begin
      lfOscEn <= ctrl_q[`PMC_F_WDTSEL];
      if (state_q == pmc_pkg::ST_SLEEP) begin
        priEn_q <= {1'b0, secForce, 1'b0};
      end else if (state_q == pmc_pkg::ST_WAKE) begin
        priEn_q <= {tgtSrc == pmc_pkg::SRC_INT || fastWake, tgtSrc == pmc_pkg::SRC_SEC || secForce,
                    tgtSrc == pmc_pkg::SRC_PRI};
      end else begin
        priEn_q <= {curSrc_q == pmc_pkg::SRC_INT || tgtSrc == pmc_pkg::SRC_INT,
                    secForce || secKeep_q || curSrc_q == pmc_pkg::SRC_SEC
                    || tgtSrc == pmc_pkg::SRC_SEC,
                    curSrc_q == pmc_pkg::SRC_PRI || tgtSrc == pmc_pkg::SRC_PRI};
      end
    end
  end

  assign priOscEn = priEn_q[0];
  assign secOscEn = priEn_q[1];
  assign intOscEn = priEn_q[2];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence runSleepNow;
    (state_q == pmc_pkg::ST_RUN) && sleepExec;
  endsequence
  sequence idleWakeSeq;
    (state_q == pmc_pkg::ST_IDLE) && wake;
  endsequence

  sleep_enter_a: assert property (runSleepNow and !idleSel
    |=> state_q == pmc_pkg::ST_SLEEP && flags_q == 3'h0 && !srcGate) else $error("sleep entry wrong");
  idle_enter_a: assert property (runSleepNow and idleSel
    |=> state_q == pmc_pkg::ST_IDLE && $stable(flags_q) && !cpuClkEn && periphClkEn)
    else $error("idle entry wrong");
  idle_stay_a: assert property ((state_q == pmc_pkg::ST_IDLE) && !wake |=> state_q == pmc_pkg::ST_IDLE)
    else $error("idle left without wake");
  idle_delay_a: assert property (idleWakeSeq |=> (!cpuClkEn && periphClkEn)[*3])
    else $error("cpu resumed too early");
  resume_src_a: assert property ((state_q == pmc_pkg::ST_IDLE_DLY) ##1 (state_q == pmc_pkg::ST_RUN)
    |-> $stable(curSrc_q)) else $error("idle resume source changed");
  switch_wait_a: assert property ((state_q == pmc_pkg::ST_RUN) && !sleepExec
    && tgtSrc != curSrc_q && !tgtReady |=> state_q == pmc_pkg::ST_RUN && $stable(curSrc_q) && cpuClkEn)
    else $error("switched before ready");
  fast_sec_a: assert property ((state_q == pmc_pkg::ST_RUN) && !sleepExec && tgtSrc == pmc_pkg::SRC_SEC
    && curSrc_q != pmc_pkg::SRC_SEC && rdySync_q[1] |=> state_q == pmc_pkg::ST_SW_OLD)
    else $error("secondary switch delayed");
  old_ticks_a: assert property ((state_q == pmc_pkg::ST_SW_OLD) && !sleepExec && pickBit(swTgt_q, rdySync_q)
    && oldTick && tickCnt_q == 2'h1 |=> state_q == pmc_pkg::ST_SW_NEW && !srcGate)
    else $error("old source count wrong");
  gate_mux_a: assert property (srcSel != $past(srcSel) |-> !srcGate || !$past(srcGate))
    else $error("mux moved while clock ungated");
  sleep_dark_a: assert property ((state_q == pmc_pkg::ST_WAKE) && !tgtReady && !(fastWake && rdySync_q[2])
    |=> !srcGate && !cpuClkEn) else $error("clocked before ready");
  two_speed_a: assert property ((state_q == pmc_pkg::ST_WAKE) && !tgtReady && fastWake && rdySync_q[2]
    |=> curSrc_q == pmc_pkg::SRC_INT && srcGate && intStable) else $error("two-speed wake wrong");
  pri_flag_a: assert property (primaryActive
    |-> curSrc_q == pmc_pkg::SRC_PRI && (srcGate || state_q == pmc_pkg::ST_SW_NEW))
    else $error("primary flag without primary clock");
  sec_pri_off_a: assert property ((state_q == pmc_pkg::ST_RUN) && curSrc_q == pmc_pkg::SRC_SEC
    && tgtSrc == pmc_pkg::SRC_SEC ##1 (state_q == pmc_pkg::ST_RUN) |-> !priOscEn)
    else $error("primary not stopped");
  sec_keep_a: assert property ((state_q == pmc_pkg::ST_SW_NEW) && swTgt_q == pmc_pkg::SRC_PRI
    && curSrc_q == pmc_pkg::SRC_SEC && newTick && tickCnt_q == 2'(`PMC_NEW_TICKS - 1)
    |=> primaryActive && !secRunning ##1 secOscEn) else $error("secondary stopped after switch back");
  ctrl_hold_a: assert property (!(apbAcc && pwrite && paddr == `PMC_ADDR_CTRL) |=> $stable(ctrl_q))
    else $error("control changed without write");
  low_keep_a: assert property ((state_q == pmc_pkg::ST_SLEEP) || (state_q == pmc_pkg::ST_IDLE)
    |=> (!$past(secForce) || secOscEn) && (!$past(ctrl_q[`PMC_F_WDTSEL]) || lfOscEn))
    else $error("oscillator stopped in low power");
  sleep_pick_a: assert property (sleepExec
    && (state_q == pmc_pkg::ST_RUN || state_q == pmc_pkg::ST_SW_OLD)
    |=> (state_q == pmc_pkg::ST_IDLE) == $past(idleSel) && $stable(srcSel)) else $error("sleep mode pick wrong");
endmodule : pmc_clock_switch

// >>> dv/pmc_osc_model.sv
// One oscillator source seen from the clock switch: start-up time, ready level, one tick per cycle.
// Assumes its enable comes from the clock switch on the same system clock.
module pmc_osc_model #(
  parameter int DIV = 2,
  parameter int START = 20
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic oscEn, // Oscillator enable
  output logic oscReady, // Source usable
  output logic oscTick // One pulse per source cycle
);
  int startCnt;
  int divCnt;
  // Ready drops at once when disabled, so a stale ready never hides a late restart
  always @(posedge clk) begin
    if (!rst_n || oscEn !== 1'b1) begin
      startCnt <= 0;
      oscReady <= 1'b0;
    end else if (startCnt < START) begin
      startCnt <= startCnt + 1;
    end else begin
      oscReady <= 1'b1;
    end
  end
  // A stopped source gives no ticks
  always @(posedge clk) begin
    if (oscReady !== 1'b1) begin
      divCnt <= 0;
      oscTick <= 1'b0;
    end else begin
      divCnt <= (divCnt == DIV - 1) ? 0 : divCnt + 1;
      oscTick <= (divCnt == DIV - 1);
    end
  end
endmodule : pmc_osc_model

// >>> dv/pmc_clock_switch_bench.sv
// Self-checking bench for the clock switch: APB master, three oscillator models, mode scenarios.
// Assumes a 50 MHz clk; the CPU start delay is shortened through the parameter.
`include "pmc_defs.svh"
module pmc_clock_switch_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPU_DLY = 3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic sleepExec = 1'b0, wakeIrq = 1'b0, wdtTimeout = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic priReady, secReady, intReady, priTick, secTick, intTick;
  pmc_pkg::pmc_src_t srcSel;
  logic srcGate, cpuClkEn, periphClkEn, priOscEn, secOscEn, intOscEn, lfOscEn;
  logic primaryActive, intStable, secRunning;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] rnd = 32'hE03EF509;
  logic [32:0] expQ[$];

  always #10 clk = ~clk;

  pmc_clock_switch #(.CPU_START_CYC(CPU_DLY)) dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .priReady(priReady), .secReady(secReady), .intReady(intReady),
    .priTick(priTick), .secTick(secTick), .intTick(intTick),
    .sleepExec(sleepExec), .wakeIrq(wakeIrq), .wdtTimeout(wdtTimeout),
    .srcSel(srcSel), .srcGate(srcGate), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
    .priOscEn(priOscEn), .secOscEn(secOscEn), .intOscEn(intOscEn), .lfOscEn(lfOscEn),
    .primaryActive(primaryActive), .intStable(intStable), .secRunning(secRunning)
  );
  pmc_osc_model priOsc (
    .clk(clk), .rst_n(rst_n), .oscEn(priOscEn), .oscReady(priReady), .oscTick(priTick));
  pmc_osc_model #(.DIV(7), .START(30)) secOsc (
    .clk(clk), .rst_n(rst_n), .oscEn(secOscEn), .oscReady(secReady), .oscTick(secTick));
  pmc_osc_model #(.DIV(3), .START(5)) internal_oscillator_block (
    .clk(clk), .rst_n(rst_n), .oscEn(intOscEn), .oscReady(intReady), .oscTick(intTick));

  task automatic report_and_stop();
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Read results are judged at the access edge, against the oldest note
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (expQ.size() == 0) begin
        chk("read without note", 33'h0, {pslverr, prdata});
      end else begin
        chk("apb read", expQ.pop_front(), {pslverr, prdata});
      end
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Idle cycle first, so a release and a new setup never meet in one time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) expQ.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wrCtrl(input logic [31:0] d);
    apb(1'b1, `PMC_ADDR_CTRL, d, 33'h0);
  endtask : wrCtrl

  // One-cycle pulse: bit 0 sleep instruction, bit 1 interrupt, bit 2 watchdog
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    {wdtTimeout, wakeIrq, sleepExec} <= m;
    @(posedge clk);
    {wdtTimeout, wakeIrq, sleepExec} <= 3'b000;
  endtask : pulse

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic waitHi(ref logic s, input int lim);
    for (int i = 0; i < lim; i++) begin
      if (s === 1'b1) break;
      cyc(1);
    end
  endtask : waitHi

  initial begin
    #400000;
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    waitHi(primaryActive, 200);
    apb(1'b0, `PMC_ADDR_CTRL, 32'h0, 33'h0);
    apb(1'b0, `PMC_ADDR_STAT, 32'h0, 33'h9);
    // Random writes to the read-only status word and random unmapped reads
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      apb(1'b1, `PMC_ADDR_STAT, rnd, 33'h0);
      apb(1'b0, `PMC_ADDR_STAT, 32'h0, 33'h9);
      apb(1'b0, {1'b1, rnd[10:2], 2'b00}, 32'h0, {1'b1, 32'h0});
    end
    wrCtrl(32'h4);
    waitHi(secReady, 100);
    wrCtrl(32'h5);
    waitHi(secRunning, 40);
    cyc(3);
    chk("secondary_run_mode", {pmc_pkg::SRC_SEC, 3'b010}, {srcSel, primaryActive, secRunning, priOscEn});
    wrCtrl(32'h0);
    cyc(5);
    chk("old source kept", {pmc_pkg::SRC_SEC, 1'b1}, {srcSel, secRunning});
    waitHi(primaryActive, 200);
    cyc(1);
    chk("back to primary", {pmc_pkg::SRC_PRI, 2'b01}, {srcSel, secRunning, secOscEn});
    wrCtrl(32'hC);
    pulse(3'b001);
    cyc(2);
    chk("idle entry", {3'b011, pmc_pkg::SRC_PRI}, {cpuClkEn, periphClkEn, primaryActive, srcSel});
    cyc(20);
    chk("idle holds", 33'h0, cpuClkEn);
    pulse(3'b010);
    cyc(1);
    chk("cpu start delay", 33'h0, cpuClkEn);
    waitHi(cpuClkEn, 20);
    chk("idle resume", {pmc_pkg::SRC_PRI, 2'b11}, {srcSel, primaryActive, cpuClkEn});
    apb(1'b0, `PMC_ADDR_CTRL, 32'h0, 33'hC);
    wrCtrl(32'h44);
    pulse(3'b001);
    cyc(3);
    chk("sleep entry", 33'h03, {srcGate, primaryActive, intStable, secRunning, priOscEn, secOscEn, lfOscEn});
    pulse(3'b100);
    cyc(3);
    chk("unclocked wake", 33'h0, srcGate);
    waitHi(primaryActive, 200);
    chk("watchdog wake", {pmc_pkg::SRC_PRI, 2'b11}, {srcSel, srcGate, primaryActive});
    apb(1'b0, `PMC_ADDR_CTRL, 32'h0, 33'h44);
    wrCtrl(32'h10);
    pulse(3'b001);
    cyc(3);
    pulse(3'b010);
    waitHi(intStable, 100);
    chk("two-speed wake", {pmc_pkg::SRC_INT, 3'b101}, {srcSel, srcGate, primaryActive, intOscEn});
    waitHi(primaryActive, 300);
    chk("primary after int", {pmc_pkg::SRC_PRI, 1'b0}, {srcSel, intStable});
    cyc(2);
    chk("int stopped", 33'h0, intOscEn);
    report_and_stop();
  end
endmodule : pmc_clock_switch_bench
